// [verilog/brm_regs.vh]
// Constants for the 256x16 masked block RAM and its register map.
`ifndef BRM_REGS_VH
`define BRM_REGS_VH
`define BRM_AW 8
`define BRM_DW 16
`define BRM_DEPTH 256
// Register byte offsets.
`define BRM_OFF_CTRL 8'h00
`define BRM_OFF_WR_ADDR 8'h04
`define BRM_OFF_WDATA 8'h08
`define BRM_OFF_WMASK 8'h0C
`define BRM_OFF_RD_ADDR 8'h10
`define BRM_OFF_RDATA 8'h14
`define BRM_OFF_STATUS 8'h18
// Control fields.
`define BRM_CTRL_WNEG 0
`define BRM_CTRL_RNEG 1
`define BRM_CTRL_WGATE 2
`define BRM_CTRL_RGATE 3
`define BRM_CTRL_ROM 4
// Command register bits (write only pulses at the control offset).
`define BRM_CTRL_WGO 8
`define BRM_CTRL_RGO 9
`define BRM_CTRL_RST 32'h0000_000C
`define BRM_RESP_OK 2'b00
`define BRM_RESP_ERR 2'b10
`endif

// [verilog/brm_array.v]
// Storage array of the block RAM with registered inputs and output.
`timescale 1ns/100ps
module brm_array #(
    parameter AW = 8,
    parameter DW = 16,
    parameter DEPTH = 256
) (
    // Clock and reset.
    input wire aclk,
    input wire aresetn,
    // Write port.
    input wire write_tick,
    input wire write_clock_gate,
    input wire write_enable,
    input wire [AW-1:0] write_address,
    input wire [DW-1:0] write_data,
    input wire [DW-1:0] write_mask,
    // Read port.
    input wire read_tick,
    input wire read_clock_gate,
    input wire fetch_enable,
    input wire [AW-1:0] read_address,
    output reg [DW-1:0] read_data
);
    reg [DW-1:0] mem [0:DEPTH-1];
    reg [AW-1:0] wa_q;
    reg [DW-1:0] wd_q;
    reg [DW-1:0] wm_q;
    reg we_q;
    reg [AW-1:0] ra_q;
    reg fetch_q;
    integer i;

    // Preload image applied at configuration; word 0 is never preloaded.
    initial begin
        for (i = 1; i < DEPTH; i = i + 1) begin
            mem[i] = i[DW-1:0];
        end
        // Location 0 stays undefined on purpose.
    end

    // Input capture; the array acts one edge later on captured values.
    always @(posedge aclk) begin
        if (!aresetn) begin
            we_q <= 1'b0;
            fetch_q <= 1'b0;
            wa_q <= {AW{1'b0}};
            wd_q <= {DW{1'b0}};
            wm_q <= {DW{1'b1}};
            ra_q <= {AW{1'b0}};
        end else begin
            we_q <= 1'b0;
            fetch_q <= 1'b0;
            if (write_tick && write_clock_gate) begin
                wa_q <= write_address;
                wd_q <= write_data;
                wm_q <= write_mask;
                we_q <= write_enable;
            end
            if (read_tick && read_clock_gate) begin
                ra_q <= read_address;
                fetch_q <= fetch_enable;
            end
        end
    end

    // Masked write: a mask bit of one keeps the stored bit.
    always @(posedge aclk) begin
        if (we_q) begin
            mem[wa_q] <= (mem[wa_q] & wm_q) | (wd_q & ~wm_q);
        end
    end

    // Read data holds unless a gated, enabled fetch was captured.
    always @(posedge aclk) begin
        if (!aresetn) begin
            read_data <= {DW{1'b0}};
        end else if (fetch_q) begin
            read_data <= mem[ra_q];
        end
    end
endmodule // brm_array

// [verilog/brm_top.v]
// AXI4-Lite wrapper that drives the masked 256x16 block RAM.
`timescale 1ns/100ps
`include "brm_regs.vh"
// Contract
// - Preloaded array with writes disabled acts as a read-only lookup.
// - Word at address zero receives no preload value.
// - Addresses and write data are captured in input registers first.
// - Mask bit zero writes that bit; mask bit one keeps it.
// - Write port takes 8-bit address and 16-bit data.
// - Read port takes 8-bit address, returns 16-bit stored word.
// - Write port acts on rising edge, falling edge by option.
// - Read port acts on rising edge, independent falling option.
// - Write edges are ignored while the write clock gate is low.
// - Read edges are ignored while the read clock gate is low.
// - Initial contents load at configuration before ports operate.
module brm_top (
    // Clock and reset.
    input wire aclk,
    input wire aresetn,
    // Write address channel.
    input wire [31:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output reg s_axi_awready,
    // Write data channel.
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output reg s_axi_wready,
    // Write response channel.
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    // Read address channel.
    input wire [31:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output reg s_axi_arready,
    // Read data channel.
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready
);
    reg [31:0] ctrl_q;
    reg [`BRM_AW-1:0] write_address_q;
    reg [`BRM_DW-1:0] wdata_q;
    reg [`BRM_DW-1:0] wmask_q;
    reg [`BRM_AW-1:0] read_address_q;
    reg [31:0] aw_q;
    reg aw_have_q;
    reg [31:0] wd_q;
    reg [3:0] ws_q;
    reg w_have_q;
    reg wgo_q;
    reg rgo_q;
    reg wphase_q;
    reg [15:0] wcount_q;
    reg [15:0] rcount_q;
    wire [`BRM_DW-1:0] rd_w;
    wire write_tick;
    wire read_tick;

    // Register map as software sees it, one aligned 32-bit word each.
    // Control word at offset zero.
    // Bit 0 moves the write port to the alternate edge slot.
    // Bit 1 moves the read port to the alternate edge slot.
    // Bit 2 is the write clock gate; low makes write edges do nothing.
    // Bit 3 is the read clock gate; low freezes the read path.
    // Bit 4 is lookup mode, which holds the write enable low.
    // Bit 8 starts one write and clears itself once the slot passes.
    // Bit 9 starts one fetch and clears itself once the slot passes.
    // Bits 8 and 9 are never stored, so a readback shows them as zero.
    // All bits above bit 4 other than the two starts are ignored.
    // Reset leaves both gates on, rising slots and writes allowed.
    //
    // Write address word at offset four.
    // Only the low byte is kept; the upper bytes read back as zero.
    // The value is copied into the array's input register at the slot.
    //
    // Write data word at offset eight.
    // The low half is kept; byte strobes pick which byte changes.
    // Nothing is stored until a write start reaches its slot.
    //
    // Mask word at offset twelve.
    // A one keeps the stored bit, a zero lets the new bit through.
    // Reset sets every bit, so a forgotten mask writes nothing.
    // That default trades convenience for safety against stray writes.
    //
    // Fetch address word at offset sixteen.
    // Only the low byte is kept, like the write address.
    //
    // Read data word at offset twenty.
    // It shows the array output, which changes only on a gated fetch.
    // A fetch with the gate low leaves the previous word in place.
    // Writes to this word are accepted and have no effect.
    //
    // Status word at offset twenty four.
    // Bit 0 shows a write start still waiting for its slot.
    // Bit 1 shows a fetch start still waiting for its slot.
    // Bits 17 to 4 count gated write slots, wrapping silently.
    // Bits 31 to 18 count gated fetch slots, wrapping silently.
    // Writes to this word are accepted and have no effect.
    //
    // Any other offset answers with a slave error and reads zero.
    //
    // Timing of one array write, counted in aclk cycles.
    // The write response to the control word sets the start flag.
    // The start waits at most two cycles for its chosen slot.
    // At the slot the address, data, mask and enable are captured.
    // One cycle later the array word takes the masked value.
    // Software polling the status word cannot see the word early.
    // A status read takes at least two cycles, so the array has settled.
    //
    // Timing of one fetch, counted in aclk cycles.
    // The start waits at most two cycles for its slot.
    // At the slot the fetch address is captured.
    // One cycle later the array output register is loaded.
    // The read data word therefore follows within three cycles.
    //
    // Why slots and not real edges.
    // The block has a single clock, so a falling edge cannot be used.
    // The phase flop splits aclk into two alternating slots instead.
    // The rising choice acts in the even slot, the falling one in the odd.
    // This keeps every flop on one edge and one timing domain.
    // The cost is up to one extra cycle of latency per operation.
    //
    // Why the start flags clear even with a gate low.
    // A gated start must not stay pending forever.
    // Otherwise raising the gate later would replay a stale command.
    // Clearing at the slot keeps each start a one-shot event.
    //
    // Why the lookup mode is a separate bit.
    // It lets software freeze the preloaded image without touching the
    // write gate, so gate counting stays meaningful in lookup mode.
    // In lookup mode a write start still counts as a gated slot.
    // The array word itself is left untouched by that slot.
    //
    // Limitations a user must know.
    // Word zero holds no preload value until software writes it.
    // A read of word zero before any write returns an undefined value.
    // Only one write and one read are under way at a time.
    // A second start issued while one is pending merges with it.
    // The counters are diagnostic only and have no overflow flag.
    //
    // Bus behaviour.
    // Write address and write data are taken in either order.
    // Each ready is a one-cycle pulse after the matching valid.
    // The response follows once both halves have been taken.
    // The response and read data stand until the master is ready.
    // The read answer comes together with the address ready pulse.

    // Merge the low half of a bus word into a 16-bit register.
    function [15:0] brm_half;
        input [15:0] old;
        input [31:0] nw;
        input [3:0] st;
        begin
            brm_half = {st[1] ? nw[15:8] : old[15:8],
                st[0] ? nw[7:0] : old[7:0]};
        end
    endfunction

    // Merge a 32-bit write into a stored word under byte strobes.
    function [31:0] brm_merge;
        input [31:0] old;
        input [31:0] nw;
        input [3:0] st;
        integer b;
        begin
            brm_merge = old;
            for (b = 0; b < 4; b = b + 1) begin
                if (st[b]) begin
                    brm_merge[b*8 +: 8] = nw[b*8 +: 8];
                end
            end
        end
    endfunction

    // The one clock stands for both port clocks; wphase_q marks the
    // half-rate falling edge slot so each port can pick its edge.
    always @(posedge aclk) begin
        if (!aresetn) begin
            wphase_q <= 1'b0;
        end else begin
            wphase_q <= ~wphase_q;
        end
    end

    // Each port acts on its chosen edge slot of the pending command.
    assign write_tick = wgo_q &
        (ctrl_q[`BRM_CTRL_WNEG] ? wphase_q : ~wphase_q);
    assign read_tick = rgo_q &
        (ctrl_q[`BRM_CTRL_RNEG] ? wphase_q : ~wphase_q);

    brm_array #(
        .AW(`BRM_AW),
        .DW(`BRM_DW),
        .DEPTH(`BRM_DEPTH)
    ) brm_array_i (
        .aclk(aclk),
        .aresetn(aresetn),
        .write_tick(write_tick),
        .write_clock_gate(ctrl_q[`BRM_CTRL_WGATE]),
        .write_enable(~ctrl_q[`BRM_CTRL_ROM]),
        .write_address(write_address_q),
        .write_data(wdata_q),
        .write_mask(wmask_q),
        .read_tick(read_tick),
        .read_clock_gate(ctrl_q[`BRM_CTRL_RGATE]),
        .fetch_enable(1'b1),
        .read_address(read_address_q),
        .read_data(rd_w)
    );

    // Write channel: address and data accepted in either order.
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `BRM_RESP_OK;
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
            aw_q <= 32'h0000_0000;
            wd_q <= 32'h0000_0000;
            ws_q <= 4'h0;
            ctrl_q <= `BRM_CTRL_RST;
            write_address_q <= {`BRM_AW{1'b0}};
            wdata_q <= {`BRM_DW{1'b0}};
            wmask_q <= {`BRM_DW{1'b1}};
            read_address_q <= {`BRM_AW{1'b0}};
            wgo_q <= 1'b0;
            rgo_q <= 1'b0;
            wcount_q <= 16'h0000;
            rcount_q <= 16'h0000;
        end else begin
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            if (write_tick) begin
                wgo_q <= 1'b0;
                if (ctrl_q[`BRM_CTRL_WGATE]) begin
                    wcount_q <= wcount_q + 16'h0001;
                end
            end
            if (read_tick) begin
                rgo_q <= 1'b0;
                if (ctrl_q[`BRM_CTRL_RGATE]) begin
                    rcount_q <= rcount_q + 16'h0001;
                end
            end
            if (s_axi_awvalid && !aw_have_q && !s_axi_awready &&
                !s_axi_bvalid) begin
                s_axi_awready <= 1'b1;
                aw_q <= s_axi_awaddr;
                aw_have_q <= 1'b1;
            end
            if (s_axi_wvalid && !w_have_q && !s_axi_wready &&
                !s_axi_bvalid) begin
                s_axi_wready <= 1'b1;
                wd_q <= s_axi_wdata;
                ws_q <= s_axi_wstrb;
                w_have_q <= 1'b1;
            end
            if (aw_have_q && w_have_q && !s_axi_bvalid) begin
                aw_have_q <= 1'b0;
                w_have_q <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= `BRM_RESP_OK;
                case (aw_q[7:0])
                `BRM_OFF_CTRL: begin
                    ctrl_q <= brm_merge(ctrl_q, wd_q, ws_q) & 32'h0000_001F;
                    if (ws_q[1] && wd_q[`BRM_CTRL_WGO]) begin
                        wgo_q <= 1'b1;
                    end
                    if (ws_q[1] && wd_q[`BRM_CTRL_RGO]) begin
                        rgo_q <= 1'b1;
                    end
                end
                `BRM_OFF_WR_ADDR: begin
                    write_address_q <= ws_q[0] ? wd_q[7:0] : write_address_q;
                end
                `BRM_OFF_WDATA: begin
                    wdata_q <= brm_half(wdata_q, wd_q, ws_q);
                end
                `BRM_OFF_WMASK: begin
                    wmask_q <= brm_half(wmask_q, wd_q, ws_q);
                end
                `BRM_OFF_RD_ADDR: begin
                    read_address_q <= ws_q[0] ? wd_q[7:0] : read_address_q;
                end
                `BRM_OFF_RDATA, `BRM_OFF_STATUS: begin
                    s_axi_bresp <= `BRM_RESP_OK;
                end
                default: begin
                    s_axi_bresp <= `BRM_RESP_ERR;
                end
                endcase
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // Read channel: one read at a time, answered the cycle after arvalid.
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `BRM_RESP_OK;
        end else begin
            s_axi_arready <= 1'b0;
            if (s_axi_rvalid) begin
                if (s_axi_rready) begin
                    s_axi_rvalid <= 1'b0;
                end
            end else if (s_axi_arvalid && !s_axi_arready) begin
                s_axi_arready <= 1'b1;
                s_axi_rvalid <= 1'b1;
                s_axi_rresp <= `BRM_RESP_OK;
                case (s_axi_araddr[7:0])
                `BRM_OFF_CTRL: s_axi_rdata <= ctrl_q;
                `BRM_OFF_WR_ADDR: s_axi_rdata <= {24'h00_0000, write_address_q};
                `BRM_OFF_WDATA: s_axi_rdata <= {16'h0000, wdata_q};
                `BRM_OFF_WMASK: s_axi_rdata <= {16'h0000, wmask_q};
                `BRM_OFF_RD_ADDR: s_axi_rdata <= {24'h00_0000, read_address_q};
                `BRM_OFF_RDATA: s_axi_rdata <= {16'h0000, rd_w};
                `BRM_OFF_STATUS: begin
                    s_axi_rdata <= {rcount_q[13:0], wcount_q[13:0],
                        2'b00, rgo_q, wgo_q};
                end
                default: begin
                    s_axi_rdata <= 32'h0000_0000;
                    s_axi_rresp <= `BRM_RESP_ERR;
                end
                endcase
            end
        end
    end
endmodule // brm_top

// [testbench/brm_props.sv]
// Concurrent checks on the AXI4-Lite ports of the block RAM wrapper.
`timescale 1ns/100ps
module brm_props (
    // Clock and reset.
    input wire aclk,
    input wire aresetn,
    // Write channels.
    input wire s_axi_awready,
    input wire s_axi_wready,
    input wire [1:0] s_axi_bresp,
    input wire s_axi_bvalid,
    input wire s_axi_bready,
    // Read channels.
    input wire s_axi_arvalid,
    input wire s_axi_arready,
    input wire [31:0] s_axi_rdata,
    input wire s_axi_rvalid,
    input wire s_axi_rready
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // Steps of a transfer; a stalled answer must not move.
    sequence s_wr_taken;
        s_axi_awready && s_axi_wready;
    endsequence
    sequence s_b_waits;
        s_axi_bvalid && !s_axi_bready;
    endsequence
    sequence s_r_waits;
        s_axi_rvalid && !s_axi_rready;
    endsequence
    a_b_follows: assert property (s_wr_taken |=> s_axi_bvalid)
        else $error("write response missing");
    a_b_holds: assert property (s_b_waits |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped");
    a_r_holds: assert property (s_r_waits |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped");
    a_r_with_ar: assert property (s_axi_arready |-> s_axi_rvalid)
        else $error("read answer not with arready");
    a_r_bound: assert property (s_axi_arvalid && !s_axi_rvalid |-> ##[1:2] s_axi_rvalid)
        else $error("read answer late");
    a_aw_pulse: assert property (s_axi_awready |=> !s_axi_awready)
        else $error("awready too long");
    a_w_pulse: assert property (s_axi_wready |=> !s_axi_wready)
        else $error("wready too long");
    a_ar_pulse: assert property (s_axi_arready |=> !s_axi_arready)
        else $error("arready too long");
endmodule // brm_props
bind brm_top brm_props brm_props_i (.aclk, .aresetn, .s_axi_awready,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready);

// [testbench/brm_axi_master.sv]
// Behavioural AXI4-Lite master standing for the fabric-side user logic.
`timescale 1ns/100ps
module brm_axi_master (
    // Clock.
    input wire aclk,
    // Write channels.
    output reg [31:0] s_axi_awaddr,
    output reg s_axi_awvalid,
    input wire s_axi_awready,
    output reg [31:0] s_axi_wdata,
    output reg [3:0] s_axi_wstrb,
    output reg s_axi_wvalid,
    input wire s_axi_wready,
    input wire s_axi_bvalid,
    output reg s_axi_bready,
    // Read channels.
    output reg [31:0] s_axi_araddr,
    output reg s_axi_arvalid,
    input wire s_axi_arready,
    input wire [31:0] s_axi_rdata,
    input wire s_axi_rvalid,
    output reg s_axi_rready
);
    // Idle at time zero.
    initial begin
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'b000;
        {s_axi_arvalid, s_axi_rready, s_axi_wstrb} = 6'h00;
        {s_axi_awaddr, s_axi_wdata, s_axi_araddr} = 96'h0;
    end
    // Whole-word write; payload is inverted once released, never left stale.
    task wr(input [31:0] a, input [31:0] d);
        begin
            @(posedge aclk);
            s_axi_awaddr <= a;
            s_axi_wdata <= d;
            s_axi_wstrb <= 4'hf;
            {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
            do begin
                @(posedge aclk);
                if (s_axi_awready) s_axi_awvalid <= 1'b0;
                if (s_axi_wready) s_axi_wvalid <= 1'b0;
            end while (!s_axi_bvalid);
            s_axi_bready <= 1'b0;
            s_axi_awaddr <= ~a;
            s_axi_wdata <= ~d;
        end
    endtask
    // Read; rready stays up until the answer is sampled.
    task rd(input [31:0] a, output [31:0] d);
        begin
            @(posedge aclk);
            s_axi_araddr <= a;
            {s_axi_arvalid, s_axi_rready} <= 2'b11;
            do begin
                @(posedge aclk);
                if (s_axi_arready) s_axi_arvalid <= 1'b0;
            end while (!s_axi_rvalid);
            d = s_axi_rdata;
            s_axi_rready <= 1'b0;
            s_axi_araddr <= ~a;
        end
    endtask
endmodule // brm_axi_master

// [testbench/brm_tb_top.sv]
// Self-checking bench for the AXI4-Lite block RAM wrapper.
`timescale 1ns/100ps
`include "brm_regs.vh"
`define CHK(n, e, s) begin samples_checked++; if ((s) !== (e)) begin \
    bad_count++; $display("mismatch %s expected %h seen %h", n, e, s); end end
module brm_tb_top;
    reg aclk;
    reg aresetn;
    wire [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata;
    wire [3:0] s_axi_wstrb;
    wire [1:0] s_axi_bresp, s_axi_rresp;
    wire s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    wire s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    wire s_axi_rvalid, s_axi_rready;
    integer bad_count = 0;
    integer samples_checked = 0;
    integer e;
    reg [31:0] rv;
    brm_top brm_top_i (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
        .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
    brm_axi_master brm_axi_master_i (.aclk, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
        .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid,
        .s_axi_rready);
    // 50 MHz clock.
    initial begin
        aclk = 1'b0;
        forever #10 aclk = ~aclk;
    end
    // Register access helpers over the partner.
    task rw(input [7:0] a, input [31:0] d);
        brm_axi_master_i.wr({24'h0, a}, d);
    endtask
    task rr(input [7:0] a);
        brm_axi_master_i.rd({24'h0, a}, rv);
    endtask
    // Polls a go flag, bounded so a stuck flag ends the wait.
    task poll(input integer b);
        repeat (50) begin
            rr(`BRM_OFF_STATUS);
            if (rv[b] === 1'b0) break;
        end
        `CHK("go clear", 1'b0, rv[b])
    endtask
    task ram_wr(input [7:0] a, input [15:0] d, input [15:0] m,
        input [31:0] c);
        begin
            rw(`BRM_OFF_WR_ADDR, {24'h0, a});
            rw(`BRM_OFF_WDATA, {16'h0, d});
            rw(`BRM_OFF_WMASK, {16'h0, m});
            rw(`BRM_OFF_CTRL, c | 32'h0000_0100);
            poll(0);
        end
    endtask
    task ram_rd(input [7:0] a, input [31:0] c);
        begin
            rw(`BRM_OFF_RD_ADDR, {24'h0, a});
            rw(`BRM_OFF_CTRL, c | 32'h0000_0200);
            poll(1);
            rr(`BRM_OFF_RDATA);
        end
    endtask
    // Reset values and an unmapped offset.
    task t_reset;
        begin
            rr(`BRM_OFF_CTRL);
            `CHK("ctrl", `BRM_CTRL_RST, rv)
            rr(`BRM_OFF_WMASK);
            `CHK("wmask", 32'h0000_FFFF, rv)
            rr(8'h1C);
            `CHK("unmapped", 32'h0000_0000, rv)
            `CHK("unmapped resp", `BRM_RESP_ERR, s_axi_rresp)
            rw(8'h1C, 32'h0000_0000);
            `CHK("unmapped wr resp", `BRM_RESP_ERR, s_axi_bresp)
        end
    endtask
    // Read-only lookup: preload visible, writes have no effect.
    task t_rom;
        begin
            ram_rd(8'h01, 32'h0000_001C);
            `CHK("rom 1", 32'h0000_0001, rv)
            ram_rd(8'hFF, 32'h0000_001C);
            `CHK("rom ff", 32'h0000_00FF, rv)
            ram_wr(8'h05, 16'hBEEF, 16'h0000, 32'h0000_001C);
            ram_rd(8'h05, 32'h0000_000C);
            `CHK("rom write", 32'h0000_0005, rv)
        end
    endtask
    // Bit mask, word zero, and each gate held off in turn.
    task t_mask_gate;
        begin
            ram_wr(8'hFE, 16'hFFFF, 16'h00FF, 32'h0000_000C);
            ram_rd(8'hFE, 32'h0000_000C);
            `CHK("mask", 32'h0000_FFFE, rv)
            ram_wr(8'h00, 16'h0F0F, 16'h0000, 32'h0000_000C);
            ram_rd(8'h00, 32'h0000_000C);
            `CHK("word0", 32'h0000_0F0F, rv)
            ram_wr(8'h40, 16'hAAAA, 16'h0000, 32'h0000_0008);
            ram_rd(8'h40, 32'h0000_000C);
            `CHK("wgate", 32'h0000_0040, rv)
            ram_rd(8'h41, 32'h0000_0004);
            `CHK("rgate", 32'h0000_0040, rv)
        end
    endtask
    // All four edge selections round trip.
    task t_edges;
        for (e = 0; e < 4; e++) begin
            ram_wr(8'h20 + e[7:0], 16'h5A00 + e[15:0], 16'h0000, 32'hC + e);
            ram_rd(8'h20 + e[7:0], 32'hC + e);
            `CHK("edge", 32'h5A00 + e, rv)
        end
    endtask
    task close_out;
        begin
            $display("checks %0d mismatches %0d", samples_checked, bad_count);
            if (bad_count == 0 && samples_checked > 0)
                $display("TEST PASSED");
            else
                $display("TEST FAILED");
            $finish;
        end
    endtask
    // Main sequence.
    initial begin
        aresetn = 1'b0;
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        t_reset;
        t_rom;
        t_mask_gate;
        t_edges;
        close_out;
    end
    // Watchdog, far beyond the few hundred cycles expected.
    initial begin
        #400000;
        bad_count++;
        close_out;
    end
endmodule // brm_tb_top
